// >>> logic/fault_sup_pkg.sv
// Constants and carrier types for the LED fault and thermal supervisor.
// Assumes a 10 MHz system clock; all analog decisions arrive as comparator levels.
`default_nettype none
package fault_sup_pkg;
    localparam int unsigned CLK_MHZ = 10;
    localparam int unsigned OPEN_FAST_US = 800;
    localparam int unsigned OPEN_FAST_CYC = OPEN_FAST_US * CLK_MHZ;
    localparam int unsigned OPEN_SLOW_US = 1600;
    localparam int unsigned OPEN_SLOW_CYC = OPEN_SLOW_US * CLK_MHZ;
    localparam int unsigned SHORT_MS = 31;
    localparam int unsigned SHORT_CYC = SHORT_MS * 1000 * CLK_MHZ;
    localparam logic [2:0] PWM_TIMEOUTS = 3'h6;
    localparam int unsigned NUM_CH = 6;
    localparam logic [1:0] SCALE_RESET = 2'h0;
    localparam logic [1:0] SCALE_LAST = 2'h3;

    typedef enum {ST_IDLE, ST_RUN, ST_HOT, ST_SHUT} sup_state_e;

    typedef struct packed {
        logic otp_low;
        logic otp_high;
        logic cool_100;
        logic ovp_over;
        logic ovp_low20;
        logic lx_ok;
    } sense_s;
endpackage
`default_nettype wire

// >>> logic/led_fault_thermal_supervisor.sv
// Fault and thermal supervisor for a six-channel LED sink driver with boost output.
// Assumes comparator inputs synchronous to i_sys_clk and one PWM-cycle pulse per period.
`timescale 1ns/10ps
`default_nettype none
module led_fault_thermal_supervisor
    import fault_sup_pkg::*;
#(
    parameter int unsigned SHORT_CYCLES = SHORT_CYC,
    parameter int unsigned OPEN_SLOW_CYCLES = OPEN_SLOW_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_enable,
    input wire logic i_pwm_cycle,
    input wire sense_s i_sense,
    input wire logic [NUM_CH-1:0] i_ch_at_target,
    input wire logic [NUM_CH-1:0] i_ch_short_detect,
    output logic [NUM_CH-1:0] o_ch_enable,
    output logic o_boost_run,
    output logic o_input_switch_on,
    output logic [1:0] o_current_scale,
    output logic o_fault_flag_n_oe
);
    // The timers are 24 bits wide, so longer limits would never expire.
    if (SHORT_CYCLES < 2 || SHORT_CYCLES > 32'hffffff || OPEN_SLOW_CYCLES < OPEN_FAST_CYC ||
        OPEN_SLOW_CYCLES > 32'hffffff) begin : g_bad_timing
        $error("Supervisor timing parameters out of range.");
    end

    sup_state_e state_r, state_nxt;
    logic [NUM_CH-1:0] good_r, dis_r, open_r;
    logic [2:0] ovt_cnt_r [NUM_CH];
    logic [2:0] sct_cnt_r [NUM_CH];
    logic [23:0] open_cnt_r [NUM_CH];
    logic [23:0] start_cnt_r;
    logic [1:0] scale_r;
    logic flag_r, ovp_armed_r, lx_seen_r;
    logic [NUM_CH-1:0] ch_timeout, open_now;
    logic active, in_shut, thermal_trip, start_fail, short_run, any_fault;
    logic [23:0] open_limit;

    // Re-enable drops the supervisor to idle, which is the only way to clear latches.
    assign active = (state_r == ST_RUN);
    assign thermal_trip = active && i_sense.otp_high;
    // The faster limit keeps bad strings from heating the die to the upper trip.
    assign open_limit = i_sense.otp_low ? 24'(OPEN_FAST_CYC) : 24'(OPEN_SLOW_CYCLES);
    assign start_fail = (state_r == ST_RUN) && !lx_seen_r && (start_cnt_r >= 24'(SHORT_CYCLES - 1));
    assign short_run = active && ovp_armed_r && i_sense.ovp_low20;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            // Not-good channels become open at lower OTP or OVERVOLTAGE_SENSE; good ones when current falls.
            assign open_now[g] = active && !dis_r[g] && !i_ch_at_target[g] &&
                (good_r[g] || i_sense.otp_low || i_sense.ovp_over);
            assign ch_timeout[g] = active && !dis_r[g] &&
                ((sct_cnt_r[g] == PWM_TIMEOUTS - 3'h1 && i_pwm_cycle && i_ch_short_detect[g]) ||
                 (ovt_cnt_r[g] == PWM_TIMEOUTS - 3'h1 && i_pwm_cycle && i_sense.ovp_over &&
                  !i_ch_at_target[g]) ||
                 (open_r[g] && open_cnt_r[g] >= open_limit - 24'h1));

            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    good_r[g] <= 1'b0;
                    dis_r[g] <= 1'b0;
                    open_r[g] <= 1'b0;
                    sct_cnt_r[g] <= 3'h0;
                    ovt_cnt_r[g] <= 3'h0;
                    open_cnt_r[g] <= 24'h0;
                end else if (state_r == ST_IDLE) begin
                    good_r[g] <= 1'b0;
                    dis_r[g] <= 1'b0;
                    open_r[g] <= 1'b0;
                    sct_cnt_r[g] <= 3'h0;
                    ovt_cnt_r[g] <= 3'h0;
                    open_cnt_r[g] <= 24'h0;
                end else begin
                    if (active && i_ch_at_target[g]) begin
                        good_r[g] <= 1'b1;
                    end
                    if (ch_timeout[g]) begin
                        dis_r[g] <= 1'b1;
                    end
                    // Below 7.5 V a shorted or Zener-bypassed channel is simply left running.
                    if (!i_ch_short_detect[g]) begin
                        sct_cnt_r[g] <= 3'h0;
                    end else if (active && i_pwm_cycle) begin
                        sct_cnt_r[g] <= sct_cnt_r[g] + 3'h1;
                    end
                    if (!i_sense.ovp_over || i_ch_at_target[g]) begin
                        ovt_cnt_r[g] <= 3'h0;
                    end else if (active && i_pwm_cycle) begin
                        ovt_cnt_r[g] <= ovt_cnt_r[g] + 3'h1;
                    end
                    if (open_now[g]) begin
                        open_r[g] <= 1'b1;
                    end else if (i_ch_at_target[g]) begin
                        open_r[g] <= 1'b0;
                    end
                    if (open_r[g] && active) begin
                        open_cnt_r[g] <= open_cnt_r[g] + 24'h1;
                    end else if (!open_r[g]) begin
                        open_cnt_r[g] <= 24'h0;
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (i_enable) state_nxt = ST_RUN;
            ST_RUN: begin
                if (start_fail || short_run) state_nxt = ST_SHUT;
                else if (thermal_trip) state_nxt = ST_HOT;
            end
            ST_HOT: if (i_sense.cool_100) state_nxt = ST_RUN;
            ST_SHUT: state_nxt = ST_SHUT;
            default: state_nxt = ST_IDLE;
        endcase
        if (!i_enable) state_nxt = ST_IDLE;
    end

    assign any_fault = (|ch_timeout) || thermal_trip || start_fail || short_run ||
        (active && i_sense.ovp_over);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_IDLE;
            scale_r <= SCALE_RESET;
            flag_r <= 1'b0;
            start_cnt_r <= 24'h0;
            ovp_armed_r <= 1'b0;
            lx_seen_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_IDLE) begin
                scale_r <= SCALE_RESET;
                flag_r <= 1'b0;
                start_cnt_r <= 24'h0;
                ovp_armed_r <= 1'b0;
                lx_seen_r <= 1'b0;
            end else begin
                if (thermal_trip && scale_r != SCALE_LAST) begin
                    scale_r <= scale_r + 2'h1;
                end
                if (any_fault) begin
                    flag_r <= 1'b1;
                end
                if (start_cnt_r != 24'hffffff) begin
                    start_cnt_r <= start_cnt_r + 24'h1;
                end
                if (i_sense.lx_ok) begin
                    lx_seen_r <= 1'b1;
                end
                if (!i_sense.ovp_low20) begin
                    ovp_armed_r <= 1'b1;
                end
            end
        end
    end

    assign in_shut = (state_r == ST_SHUT);
    assign o_ch_enable = active ? ~dis_r : {NUM_CH{1'b0}};
    assign o_boost_run = active;
    assign o_input_switch_on = (state_r != ST_IDLE) && !in_shut;
    assign o_current_scale = scale_r;
    assign o_fault_flag_n_oe = flag_r;

    chk_hot_all_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_r == ST_HOT) |-> (o_ch_enable == '0 && !o_boost_run))
        else $error("Channels active during thermal shutdown.");
    chk_trip_to_hot: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (thermal_trip && !start_fail && !short_run && i_enable) |=> (state_r == ST_HOT))
        else $error("Upper trip did not enter shutdown.");
    chk_scale_step: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (thermal_trip && i_enable && scale_r != SCALE_LAST) |=> (scale_r == $past(scale_r) + 2'h1))
        else $error("Current scale did not step.");
    chk_scale_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (scale_r == SCALE_LAST && i_enable && state_r != ST_IDLE) |=> (scale_r == SCALE_LAST))
        else $error("Current scale left final step.");
    chk_flag_latch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_fault_flag_n_oe && state_r != ST_IDLE) |=> o_fault_flag_n_oe)
        else $error("Fault flag cleared while enabled.");
    chk_fault_sets: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (|ch_timeout) |=> o_fault_flag_n_oe)
        else $error("Channel time-out did not set flag.");
    chk_disable_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (ch_timeout[0] && i_enable) |=> !o_ch_enable[0])
        else $error("Timed-out channel still enabled.");
    chk_shut_final: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (in_shut && i_enable) |=> (in_shut && !o_input_switch_on))
        else $error("Permanent shutdown left.");
    chk_enable_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_enable |=> (state_r == ST_IDLE))
        else $error("Not idle after enable low.");
    cov_thermal: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_r == ST_HOT) ##1 (state_r == ST_RUN));
    cov_last: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) scale_r == SCALE_LAST);
    cov_timeout: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) |ch_timeout);
    cov_shut: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) in_shut);
endmodule // led_fault_thermal_supervisor
`default_nettype wire

// >>> tb/led_plant_model.sv
// Behavioural far side of the supervisor: LED strings and the PWM timebase.
// Assumes the bench sets which strings are open; a PWM pulse comes every 10 clocks.
`timescale 1ns/10ps
`default_nettype none
module led_plant_model
    import fault_sup_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [NUM_CH-1:0] i_ch_enable,
    input wire logic [NUM_CH-1:0] i_open_mask,
    output logic o_pwm_cycle,
    output logic [NUM_CH-1:0] o_ch_at_target
);
    logic [3:0] pwm_cnt_r;
    // A string reaches its target one clock after its sink turns on, unless it is open.
    // An open or switched-off string never reports target, so it is no kinder than a real one.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwm_cnt_r <= 4'h0;
            o_pwm_cycle <= 1'b0;
            o_ch_at_target <= '0;
        end else begin
            pwm_cnt_r <= (pwm_cnt_r == 4'h9) ? 4'h0 : pwm_cnt_r + 4'h1;
            o_pwm_cycle <= (pwm_cnt_r == 4'h9);
            o_ch_at_target <= i_ch_enable & ~i_open_mask;
        end
    end
endmodule // led_plant_model
`default_nettype wire

// >>> tb/led_fault_thermal_supervisor_bench.sv
// Self-checking bench for the LED fault and thermal supervisor.
// Assumes the plant model closes the current loop; the start time-out is shortened to 200.
`timescale 1ns/10ps
`default_nettype none
module led_fault_thermal_supervisor_bench;
    import fault_sup_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic en = 1'b0;
    sense_s sense = '0;
    logic [NUM_CH-1:0] short_det = '0;
    logic [NUM_CH-1:0] open_mask = '0;
    logic pwm;
    logic [NUM_CH-1:0] at_tgt;
    logic [NUM_CH-1:0] ch_en;
    logic boost;
    logic in_sw;
    logic [1:0] scale;
    logic flag;
    int errors = 0;
    int n_tests = 0;
    always #50 i_sys_clk = ~i_sys_clk;
    led_fault_thermal_supervisor #(.SHORT_CYCLES(200), .OPEN_SLOW_CYCLES(16000)) u_dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_enable(en), .i_pwm_cycle(pwm),
        .i_sense(sense), .i_ch_at_target(at_tgt), .i_ch_short_detect(short_det),
        .o_ch_enable(ch_en), .o_boost_run(boost), .o_input_switch_on(in_sw),
        .o_current_scale(scale), .o_fault_flag_n_oe(flag));
    led_plant_model u_plant (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ch_enable(ch_en),
        .i_open_mask(open_mask), .o_pwm_cycle(pwm), .o_ch_at_target(at_tgt));
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Dropping enable for one edge is the only way out of a latched fault.
    task automatic restart(input logic lx);
        @(posedge i_sys_clk);
        en <= 1'b0;
        sense <= '0;
        short_det <= '0;
        open_mask <= '0;
        cyc(2);
        check(8'(flag), 8'h0);
        check(8'(scale), 8'h0);
        @(posedge i_sys_clk);
        en <= 1'b1;
        sense.lx_ok <= lx;
        cyc(3);
    endtask
    task automatic t_short();
        restart(1'b1);
        check(8'(ch_en), 8'h3f);
        // Strings below the short level must survive one cycle past the six-cycle time-out.
        repeat (7) @(posedge i_sys_clk iff pwm);
        cyc(1);
        check(8'(ch_en), 8'h3f);
        @(posedge i_sys_clk);
        short_det <= 6'h04;
        repeat (5) @(posedge i_sys_clk iff pwm);
        cyc(1);
        check(8'(ch_en), 8'h3f);
        @(posedge i_sys_clk iff pwm);
        cyc(2);
        check(8'(ch_en), 8'h3b);
        check(8'(boost), 8'h1);
        check(8'(flag), 8'h1);
    endtask
    task automatic t_thermal();
        restart(1'b1);
        for (int i = 1; i <= 4; i++) begin
            @(posedge i_sys_clk);
            sense.otp_high <= 1'b1;
            cyc(3);
            check(8'(boost), 8'h0);
            check(8'(ch_en), 8'h00);
            check(8'(scale), (i > 3) ? 8'h3 : 8'(i));
            check(8'(in_sw), 8'h1);
            check(8'(flag), 8'h1);
            @(posedge i_sys_clk);
            sense.otp_high <= 1'b0;
            sense.cool_100 <= 1'b1;
            cyc(3);
            check(8'(boost), 8'h1);
            check(8'(ch_en), 8'h3f);
            @(posedge i_sys_clk);
            sense.cool_100 <= 1'b0;
        end
    endtask
    // A good string dropping below target under the lower threshold takes the fast time-out.
    task automatic t_open_fast();
        restart(1'b1);
        @(posedge i_sys_clk);
        sense.otp_low <= 1'b1;
        open_mask <= 6'h01;
        cyc(OPEN_FAST_CYC - 100);
        check(8'(ch_en), 8'h3f);
        check(8'(flag), 8'h0);
        cyc(200);
        check(8'(ch_en), 8'h3e);
        check(8'(flag), 8'h1);
    endtask
    task automatic t_start_fail();
        restart(1'b0);
        cyc(250);
        check(8'(boost), 8'h0);
        check(8'(flag), 8'h1);
        @(posedge i_sys_clk);
        sense.lx_ok <= 1'b1;
        cyc(20);
        check(8'(in_sw), 8'h0);
    endtask
    task automatic t_out_short();
        restart(1'b1);
        @(posedge i_sys_clk);
        sense.ovp_low20 <= 1'b1;
        cyc(3);
        check(8'(in_sw), 8'h0);
        check(8'(boost), 8'h0);
        check(8'(flag), 8'h1);
    endtask
    // Output above its limit times out only the string that never reaches target.
    task automatic t_ovp();
        restart(1'b1);
        @(posedge i_sys_clk);
        sense.ovp_over <= 1'b1;
        open_mask <= 6'h02;
        cyc(1);
        check(8'(flag), 8'h1);
        repeat (5) @(posedge i_sys_clk iff pwm);
        cyc(1);
        check(8'(ch_en), 8'h3f);
        @(posedge i_sys_clk iff pwm);
        cyc(2);
        check(8'(ch_en), 8'h3d);
        check(8'(boost), 8'h1);
    endtask
    initial begin
        #3000000;
        errors++;
        complete_run();
    end
    initial begin
        cyc(3);
        check({boost, in_sw, flag, scale, 3'h0}, 8'h00);
        check(8'(ch_en), 8'h00);
        @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_short();
        t_thermal();
        t_open_fast();
        t_start_fail();
        t_out_short();
        t_ovp();
        complete_run();
    end
endmodule // led_fault_thermal_supervisor_bench
`default_nettype wire
